// *** core/ccu_pkg.sv ***
// package: constants, types and helpers of the compare/capture unit
package ccu_pkg;

    // ==========================================================
    // sizes
    localparam int NUM_CC = 5;               // crc, cc1..cc3, cc4
    localparam int NUM_CM = 8;               // port 4 compare registers
    localparam int NUM_CR = NUM_CC + NUM_CM; // all 16-bit compare values
    localparam int NUM_CH = NUM_CR + 8;      // 5 port1, 8 port4, 8 port5 lines

    // ==========================================================
    // register offsets
    localparam logic [7:0] ADR_CC_MODE_EN  = 8'hC1;
    localparam logic [7:0] ADR_T2_CTRL     = 8'hC8;
    localparam logic [7:0] ADR_CONC_CTRL   = 8'hC9;
    localparam logic [7:0] ADR_P4_CMP_EN   = 8'hF6;
    localparam logic [7:0] ADR_P4_TMR_SEL  = 8'hF7;
    localparam logic [7:0] ADR_T2_CNT_LOW  = 8'hCC;
    localparam logic [7:0] ADR_T2_CNT_HIGH = 8'hCD;
    localparam logic [7:0] ADR_CT_RLD_LOW  = 8'hDE;
    localparam logic [7:0] ADR_CT_RLD_HIGH = 8'hDF;
    localparam logic [7:0] ADR_LVL_P1      = 8'hD4;
    localparam logic [7:0] ADR_LVL_P4      = 8'hD5;
    localparam logic [7:0] ADR_LVL_P5      = 8'hD6;
    // low byte offsets of crc, cc1, cc2, cc3, cc4, cm0..cm7 (high = low + 1)
    localparam logic [NUM_CR-1:0][7:0] CMP_BASE = {
        8'hEE, 8'hEC, 8'hEA, 8'hE8, 8'hE6, 8'hE4, 8'hE2, 8'hE0,
        8'hCE, 8'hC6, 8'hC4, 8'hC2, 8'hCA};

    // ==========================================================
    // field positions and codes
    localparam int T2_IN_LO   = 0;   // two input-select bits
    localparam int T2_CM_BIT  = 2;   // compare mode bit
    localparam int T2_RLD_LO  = 3;   // two reload-mode bits
    localparam int CC4_SEL    = 0;   // concurrent mode select
    localparam int CC4_MODE   = 1;   // two mode bits
    localparam int CC4_OE     = 3;   // concurrent output enable
    localparam int CC4_CNT    = 4;   // three output count bits
    localparam logic [1:0] MODE_OFF   = 2'h0;
    localparam logic [1:0] MODE_CAPP  = 2'h1;
    localparam logic [1:0] MODE_CMP   = 2'h2;
    localparam logic [1:0] MODE_CAPW  = 2'h3;
    localparam logic [1:0] RLD_AUTO   = 2'h2;
    localparam logic [1:0] RLD_PIN    = 2'h3;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // ==========================================================
    // timing: clock cycles per timer step
    localparam int T2_DIV = 12;
    localparam int CT_DIV = 2;

    // ==========================================================
    // carriers and state
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ccu_bus_s;

    typedef struct packed {
        logic line;
        logic oe;
    } ccu_cell_s;

    typedef struct packed {
        logic [7:0]               rdata;
        logic [7:0]               timer2_control;
        logic [7:0]               cc_mode_enable;
        logic [7:0]               cc4con;
        logic [7:0]               port4_compare_enable;
        logic [7:0]               port4_compare_timer_select;
        logic [4:0]               lvl_p1;
        logic [7:0]               lvl_p4;
        logic [7:0]               lvl_p5;
        logic [15:0]              t2_cnt;
        logic [3:0]               t2_div;
        logic [15:0]              ct_cnt;
        logic [15:0]              ct_rel;
        logic [3:0]               ct_div;
        logic                     ct_run;
        logic [NUM_CR-1:0][15:0]  val;
        logic [NUM_CM-1:0][15:0]  shadow;
        logic [NUM_CR-1:0]        mt;
        logic                     t2_ovf;
        logic                     ct_ovf;
        logic [NUM_CC-1:0]        irq;
        logic [NUM_CC-1:0]        cap_s1;
        logic [NUM_CC-1:0]        cap_s2;
        logic [NUM_CC-1:0]        cap_s3;
        logic [NUM_CC-1:0]        cap_lvl;
        logic [3:0]               rex;   // s1, s2, s3, settled level
    } ccu_state_s;

    // equality of a timer count with a compare value
    function automatic logic ccu_match(input logic [15:0] cnt, input logic [15:0] cmp);
        return cnt == cmp;
    endfunction

endpackage

// *** core/ccu_cmp_cell.sv ***
// compare output cell: one line driven by a match in mode 0 or 1
`timescale 1ns/10ps
`default_nettype none
module ccu_cmp_cell (
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    input  wire logic i_enable,
    input  wire logic i_match,
    input  wire logic i_mode1,
    input  wire logic i_level,
    input  wire logic i_clear,
    output logic      o_line,
    output logic      o_oe
);
    import ccu_pkg::*;

    ccu_cell_s st_r;
    ccu_cell_s st_nxt;

    // next line level
    always_comb begin
        st_nxt    = st_r;
        st_nxt.oe = i_enable;
        if (!i_enable) begin
            st_nxt.line = 1'b0;
        end else if (i_match) begin
            st_nxt.line = i_mode1 ? i_level : 1'b1;
        end else if (i_clear && !i_mode1) begin
            st_nxt.line = 1'b0;
        end
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_line = st_r.line;
    assign o_oe   = st_r.oe;

    chk_mode0_rise: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_enable && i_match && !i_mode1 |=> o_line)
        else $error("mode 0 match did not raise the line");
    chk_mode1_level: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_enable && i_match && i_mode1 |=> o_line == $past(i_level))
        else $error("mode 1 match did not take the software level");
endmodule
`default_nettype wire

// *** core/ccu_core.sv ***
// compare/capture unit: timers, compare and capture registers, outputs
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ccu_core (
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire ccu_pkg::ccu_bus_s i_bus,
    input  wire logic [4:0]       i_p1_cap,
    input  wire logic             i_t2_reload_pin,
    output logic [7:0]            o_rdata,
    output logic [4:0]            o_p1_cmp,
    output logic [4:0]            o_p1_oe,
    output logic [7:0]            o_p4_cmp,
    output logic [7:0]            o_p4_oe,
    output logic [7:0]            o_p5_cmp,
    output logic [7:0]            o_p5_oe,
    output logic [4:0]            o_cmp_irq
);
    import ccu_pkg::*;

    ccu_state_s s;
    ccu_state_s n;

    logic [NUM_CH-1:0] ch_en;
    logic [NUM_CH-1:0] ch_match;
    logic [NUM_CH-1:0] ch_mode1;
    logic [NUM_CH-1:0] ch_level;
    logic [NUM_CH-1:0] ch_clear;
    logic [NUM_CH-1:0] ch_line;
    logic [NUM_CH-1:0] ch_oe;

    // mode field of one of the five compare/capture registers
    function automatic logic [1:0] cc_mode(input ccu_state_s st, input int i);
        if (i == NUM_CC - 1) begin
            return st.cc4con[CC4_MODE +: 2];
        end
        return st.cc_mode_enable[2 * i +: 2];
    endfunction

    // ==========================================================
    // next state
    always_comb begin
        logic       t2_step;
        logic       ct_step;
        logic       cap_edge;
        logic [1:0] rld;
        t2_step  = 1'b0;
        ct_step  = 1'b0;
        cap_edge = 1'b0;
        rld      = s.timer2_control[T2_RLD_LO +: 2];
        n        = s;
        n.rdata  = RESET_BYTE;
        n.mt     = '0;
        n.t2_ovf = 1'b0;
        n.ct_ovf = 1'b0;
        n.irq    = '0;

        // pin synchronisers; a level counts once stages 2 and 3 agree
        n.cap_s1 = i_p1_cap;
        n.cap_s2 = s.cap_s1;
        n.cap_s3 = s.cap_s2;
        n.rex    = {i_t2_reload_pin, s.rex[3], s.rex[2], s.rex[0]};
        if (s.rex[2] == s.rex[1]) begin
            n.rex[0] = s.rex[1];
        end

        // timer 2 step: runs while an input is selected
        if (s.timer2_control[T2_IN_LO +: 2] != 2'h0) begin
            if (s.t2_div == 4'(T2_DIV - 1)) begin
                n.t2_div = '0;
                t2_step  = 1'b1;
            end else begin
                n.t2_div = s.t2_div + 4'h1;
            end
        end
        if (t2_step) begin
            if (s.t2_cnt == 16'hFFFF) begin
                n.t2_ovf = 1'b1;
                n.t2_cnt = (rld == RLD_AUTO) ? s.val[0] : 16'h0000;
            end else begin
                n.t2_cnt = s.t2_cnt + 16'h0001;
            end
        end
        // falling edge at the reload pin, settled level only
        if (rld == RLD_PIN && s.rex[2] == s.rex[1] && !s.rex[1] && s.rex[0]) begin
            n.t2_cnt = s.val[0];
            t2_step  = 1'b1;
        end

        // compare timer step
        if (s.ct_run) begin
            if (s.ct_div == 4'(CT_DIV - 1)) begin
                n.ct_div = '0;
                ct_step  = 1'b1;
            end else begin
                n.ct_div = s.ct_div + 4'h1;
            end
        end
        if (ct_step) begin
            if (s.ct_cnt == 16'hFFFF) begin
                n.ct_ovf = 1'b1;
                n.ct_cnt = s.ct_rel;
                n.shadow = s.val[NUM_CR-1:NUM_CC];
            end else begin
                n.ct_cnt = s.ct_cnt + 16'h0001;
            end
        end

        // register writes
        if (i_bus.wr) begin
            case (i_bus.addr)
                ADR_CC_MODE_EN:  n.cc_mode_enable = i_bus.wdata;
                ADR_T2_CTRL:     n.timer2_control = i_bus.wdata;
                ADR_CONC_CTRL: begin
                    n.cc4con = i_bus.wdata;
                    if (i_bus.wdata[CC4_OE]) begin
                        n.cc4con[CC4_SEL] = 1'b1;
                    end
                end
                ADR_P4_CMP_EN:   n.port4_compare_enable = i_bus.wdata;
                ADR_P4_TMR_SEL:  n.port4_compare_timer_select = i_bus.wdata;
                ADR_T2_CNT_LOW:  n.t2_cnt[7:0] = i_bus.wdata;
                ADR_T2_CNT_HIGH: n.t2_cnt[15:8] = i_bus.wdata;
                ADR_CT_RLD_HIGH: n.ct_rel[15:8] = i_bus.wdata;
                ADR_CT_RLD_LOW: begin
                    n.ct_rel[7:0] = i_bus.wdata;
                    n.ct_cnt = {s.ct_rel[15:8], i_bus.wdata};
                    n.ct_div = '0;
                    n.ct_run = 1'b1;
                end
                ADR_LVL_P1:      n.lvl_p1 = i_bus.wdata[4:0];
                ADR_LVL_P4:      n.lvl_p4 = i_bus.wdata;
                ADR_LVL_P5:      n.lvl_p5 = i_bus.wdata;
                default: begin
                end
            endcase
            for (int i = 0; i < NUM_CR; i++) begin
                if (i_bus.addr == CMP_BASE[i]) begin
                    n.val[i][7:0] = i_bus.wdata;
                    if (i < NUM_CC && cc_mode(s, i) == MODE_CAPW) begin
                        n.val[i] = s.t2_cnt;
                    end
                end
                if (i_bus.addr == CMP_BASE[i] + 8'h01) begin
                    n.val[i][15:8] = i_bus.wdata;
                end
            end
        end

        // capture on a settled rising edge at a port 1 pin
        for (int i = 0; i < NUM_CC; i++) begin
            cap_edge = s.cap_s2[i] == s.cap_s3[i] && s.cap_s3[i] && !s.cap_lvl[i];
            if (s.cap_s2[i] == s.cap_s3[i]) begin
                n.cap_lvl[i] = s.cap_s3[i];
            end
            if (cap_edge && cc_mode(s, i) == MODE_CAPP) begin
                n.val[i] = s.t2_cnt;
            end
        end

        // matches against the count just taken
        for (int i = 0; i < NUM_CC; i++) begin
            n.mt[i] = t2_step && ccu_match(n.t2_cnt, s.val[i]);
        end
        // port 4 registers follow the timer picked by their select bit
        for (int j = 0; j < NUM_CM; j++) begin
            if (s.port4_compare_timer_select[j]) begin
                n.mt[NUM_CC + j] = ct_step && ccu_match(n.ct_cnt, s.shadow[j]);
            end else begin
                n.mt[NUM_CC + j] = t2_step && ccu_match(n.t2_cnt, s.val[NUM_CC + j]);
            end
        end
        for (int i = 0; i < NUM_CC; i++) begin
            n.irq[i] = s.mt[i] && cc_mode(s, i) == MODE_CMP;
        end

        // register reads, data in the following cycle only
        if (i_bus.rd) begin
            case (i_bus.addr)
                ADR_CC_MODE_EN:  n.rdata = s.cc_mode_enable;
                ADR_T2_CTRL:     n.rdata = s.timer2_control;
                ADR_CONC_CTRL:   n.rdata = s.cc4con;
                ADR_P4_CMP_EN:   n.rdata = s.port4_compare_enable;
                ADR_P4_TMR_SEL:  n.rdata = s.port4_compare_timer_select;
                ADR_T2_CNT_LOW:  n.rdata = s.t2_cnt[7:0];
                ADR_T2_CNT_HIGH: n.rdata = s.t2_cnt[15:8];
                ADR_CT_RLD_LOW:  n.rdata = s.ct_rel[7:0];
                ADR_CT_RLD_HIGH: n.rdata = s.ct_rel[15:8];
                ADR_LVL_P1:      n.rdata = {3'h0, s.lvl_p1};
                ADR_LVL_P4:      n.rdata = s.lvl_p4;
                ADR_LVL_P5:      n.rdata = s.lvl_p5;
                default:         n.rdata = RESET_BYTE;
            endcase
            for (int i = 0; i < NUM_CR; i++) begin
                if (i_bus.addr == CMP_BASE[i]) begin
                    n.rdata = s.val[i][7:0];
                end
                if (i_bus.addr == CMP_BASE[i] + 8'h01) begin
                    n.rdata = s.val[i][15:8];
                end
            end
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // ==========================================================
    // per-line configuration of the 21 compare outputs
    always_comb begin
        for (int i = 0; i < NUM_CC; i++) begin
            ch_en[i]    = cc_mode(s, i) == MODE_CMP;
            ch_match[i] = s.mt[i];
            ch_mode1[i] = (i == NUM_CC - 1) ? s.cc4con[CC4_SEL] : s.timer2_control[T2_CM_BIT];
            ch_level[i] = s.lvl_p1[i];
            ch_clear[i] = s.t2_ovf;
        end
        for (int j = 0; j < NUM_CM; j++) begin
            ch_en[NUM_CC + j]    = s.port4_compare_enable[j];
            ch_match[NUM_CC + j] = s.mt[NUM_CC + j];
            ch_mode1[NUM_CC + j] = !s.port4_compare_timer_select[j];
            ch_level[NUM_CC + j] = s.lvl_p4[j];
            ch_clear[NUM_CC + j] = s.port4_compare_timer_select[j] ? s.ct_ovf : s.t2_ovf;
        end
        for (int k = 0; k < 8; k++) begin
            ch_en[NUM_CR + k]    = ch_en[NUM_CC - 1] && s.cc4con[CC4_OE]
                                   && 3'(k) <= s.cc4con[CC4_CNT +: 3];
            ch_match[NUM_CR + k] = s.mt[NUM_CC - 1];
            ch_mode1[NUM_CR + k] = 1'b1;
            ch_level[NUM_CR + k] = s.lvl_p5[k];
            ch_clear[NUM_CR + k] = s.t2_ovf;
        end
    end

    // output cells
    for (genvar g = 0; g < NUM_CH; g++) begin : g_cell
        ccu_cmp_cell u_cell (
            .i_clk     (i_clk),
            .i_reset_n (i_reset_n),
            .i_enable  (ch_en[g]),
            .i_match   (ch_match[g]),
            .i_mode1   (ch_mode1[g]),
            .i_level   (ch_level[g]),
            .i_clear   (ch_clear[g]),
            .o_line    (ch_line[g]),
            .o_oe      (ch_oe[g])
        );
    end

    // outputs
    assign o_rdata   = s.rdata;
    assign o_cmp_irq = s.irq;
    assign o_p1_cmp  = ch_line[NUM_CC-1:0];
    assign o_p1_oe   = ch_oe[NUM_CC-1:0];
    assign o_p4_cmp  = ch_line[NUM_CR-1:NUM_CC];
    assign o_p4_oe   = ch_oe[NUM_CR-1:NUM_CC];
    assign o_p5_cmp  = ch_line[NUM_CH-1:NUM_CR];
    assign o_p5_oe   = ch_oe[NUM_CH-1:NUM_CR];

    // ==========================================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    chk_reload_start: assert property (
        i_bus.wr && i_bus.addr == ADR_CT_RLD_LOW
        |=> s.ct_run && s.ct_cnt == {$past(s.ct_rel[15:8]), $past(i_bus.wdata)})
        else $error("reload low write did not start the compare timer");
    chk_ct_reload: assert property (
        s.ct_ovf && !$past(i_bus.wr) |-> s.ct_cnt == s.ct_rel)
        else $error("compare timer did not reload on overflow");
    chk_shadow_load: assert property (
        s.ct_ovf |-> s.shadow[0] == $past(s.val[NUM_CC]))
        else $error("shadow latch not loaded at compare timer overflow");
    chk_t2_autoreload: assert property (
        s.t2_ovf && $past(s.timer2_control[T2_RLD_LO +: 2]) == RLD_AUTO && !$past(i_bus.wr)
        |-> s.t2_cnt == $past(s.val[0]))
        else $error("timer 2 auto reload value wrong");
    chk_mode_autoset: assert property (
        i_bus.wr && i_bus.addr == ADR_CONC_CTRL && i_bus.wdata[CC4_OE]
        |=> s.cc4con[CC4_SEL])
        else $error("output enable did not set the mode select bit");
    chk_capture_write: assert property (
        i_bus.wr && i_bus.addr == CMP_BASE[1] && s.cc_mode_enable[3:2] == MODE_CAPW
        |=> s.val[1] == $past(s.t2_cnt))
        else $error("low byte write did not capture timer 2");
    chk_t2_ctrl_read: assert property (
        i_bus.wr && i_bus.addr == ADR_T2_CTRL ##1 i_bus.rd && i_bus.addr == ADR_T2_CTRL
        |=> o_rdata == $past(i_bus.wdata, 2))
        else $error("timer 2 control did not read back");
    chk_p5_count: assert property (
        s.cc4con[CC4_CNT +: 3] == 3'h0 && $past(s.cc4con[CC4_CNT +: 3]) == 3'h0 |-> o_p5_oe[7:1] == 7'h00)
        else $error("port 5 line beyond the count is driven");
    chk_irq_match: assert property (
        s.mt[1] && s.cc_mode_enable[3:2] == MODE_CMP |=> o_cmp_irq[1])
        else $error("compare match did not request an interrupt");
    chk_mode0_clear: assert property (
        ch_en[1] && !ch_mode1[1] && s.t2_ovf && !s.mt[1] |=> !o_p1_cmp[1])
        else $error("mode 0 line not lowered at timer 2 overflow");
    chk_t2_increment: assert property (
        s.timer2_control[T2_IN_LO +: 2] != 2'h0 && s.t2_div == 4'(T2_DIV - 1) && s.t2_cnt != 16'hFFFF
        && s.timer2_control[T2_RLD_LO +: 2] != RLD_PIN && !i_bus.wr |=> s.t2_cnt == $past(s.t2_cnt) + 16'h0001)
        else $error("timer 2 did not count up by one");
    chk_rdata_idle: assert property (
        !$past(i_bus.rd) |-> o_rdata == RESET_BYTE)
        else $error("read data not zero outside the read answer cycle");
    chk_p4_enable: assert property (
        o_p4_oe == $past(s.port4_compare_enable))
        else $error("port 4 drive enable does not follow its enable bits");
    chk_irq_conc: assert property (
        s.mt[NUM_CC - 1] && s.cc4con[CC4_MODE +: 2] == MODE_CMP |=> o_cmp_irq[NUM_CC - 1])
        else $error("concurrent compare match did not request an interrupt");
    chk_p5_match: assert property (
        ch_en[NUM_CR] && s.mt[NUM_CC - 1] |=> o_p5_cmp[0] == $past(s.lvl_p5[0]))
        else $error("port 5 line did not take its level on a match");

    cov_ct_overflow: cover property (s.ct_ovf);
    cov_t2_overflow: cover property (s.t2_ovf);
    cov_concurrent: cover property (o_p5_cmp[0] && o_p1_cmp[4]);
    cov_pin_capture: cover property (s.cap_lvl[0] && !$past(s.cap_lvl[0]));
endmodule
`default_nettype wire

// *** testbench/ccu_pin_model.sv ***
// pin model: drives the capture pins and the timer 2 reload pin
`timescale 1ns/10ps
`default_nettype none
module ccu_pin_model (
    input  wire logic       i_clk,
    output logic [4:0]      o_cap,
    output logic            o_reload
);
    // ==========================================
    // idle levels: capture pins low, reload pin high
    initial begin
        o_cap    = 5'h00;
        o_reload = 1'b1;
    end

    // one rising edge, held past the three-stage synchroniser
    task automatic cap_edge(input int k);
        @(posedge i_clk);
        o_cap <= o_cap | (5'h01 << k);
        repeat (6) @(posedge i_clk);
        o_cap <= o_cap & ~(5'h01 << k);
    endtask

    // one falling edge on the reload pin, then back to idle
    task automatic reload_fall();
        @(posedge i_clk);
        o_reload <= 1'b0;
        repeat (6) @(posedge i_clk);
        o_reload <= 1'b1;
    endtask
endmodule
`default_nettype wire

// *** testbench/compare_capture_unit_config_bench.sv ***
// testbench of the compare/capture unit
`timescale 1ns/10ps
`default_nettype none
module compare_capture_unit_config_bench;
    import ccu_pkg::*;
    logic        clk;
    logic        rst_n;
    ccu_bus_s    bus;
    logic [4:0]  cap, p1, p1_oe, irq;
    logic        rld;
    logic [7:0]  rdata, p4, p4_oe, p5, p5_oe, rv;
    logic [20:0] pins;
    int          failures;
    int          n_compared;

    assign pins = {p5, p4, p1};

    ccu_core i_dut (.i_clk(clk), .i_reset_n(rst_n), .i_bus(bus), .i_p1_cap(cap),
        .i_t2_reload_pin(rld), .o_rdata(rdata), .o_p1_cmp(p1), .o_p1_oe(p1_oe),
        .o_p4_cmp(p4), .o_p4_oe(p4_oe), .o_p5_cmp(p5), .o_p5_oe(p5_oe), .o_cmp_irq(irq));
    ccu_pin_model i_pins (.i_clk(clk), .o_cap(cap), .o_reload(rld));

    // 100 ns clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ==========================================
    // common tasks
    task automatic results();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '{a, d, 1'b0, 1'b0};
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '{a, 8'h00, 1'b0, 1'b0};
        #1 rv = rdata;
    endtask

    // high byte first, the low byte write completes the value
    task automatic w16(input logic [7:0] a, input logic [15:0] v);
        wr(a + 8'h01, v[15:8]);
        wr(a, v[7:0]);
    endtask

    // bounded wait for one output line to reach a level
    task automatic wt(input int b, input logic v, input int lim);
        int i;
        #1;
        for (i = 0; i < lim && pins[b] !== v; i++) @(posedge clk) #1;
        n_compared++;
        if (pins[b] !== v) begin
            failures++;
            $display("[ERR] %0t timeout on line %0d", $time, b);
            results();
        end
    endtask

    // ==========================================
    // scenarios
    task automatic s_regs();
        logic [7:0] adr [5] = '{ADR_CC_MODE_EN, ADR_T2_CTRL, ADR_CONC_CTRL, ADR_P4_CMP_EN, ADR_P4_TMR_SEL};
        foreach (adr[k]) begin
            rd(adr[k]);
            chk(rv, RESET_BYTE, "reset value");
            wr(adr[k], 8'hA4);
            rd(adr[k]);
            chk(rv, 8'hA4, "read back");
            wr(adr[k], 8'h00);
        end
        wr(ADR_CONC_CTRL, 8'h08);
        rd(ADR_CONC_CTRL);
        chk(rv, 8'h09, "enable sets mode");
        rd(8'hB0);
        chk(rv, 8'h00, "unmapped");
    endtask

    // write then read with no idle cycle between the two strobes
    task automatic s_b2b();
        @(posedge clk);
        bus <= '{ADR_T2_CTRL, 8'hA4, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '{ADR_T2_CTRL, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '0;
        #1 rv = rdata;
        chk(rv, 8'hA4, "back to back read");
        wr(ADR_T2_CTRL, 8'h00);
    endtask

    task automatic s_cmp();
        w16(CMP_BASE[1], 16'h0005);
        wr(ADR_CC_MODE_EN, 8'h08);
        w16(ADR_T2_CNT_LOW, 16'h0000);
        wr(ADR_T2_CTRL, 8'h01);
        wt(1, 1'b1, 120);
        chk({3'h0, irq}, 8'h02, "irq");
        chk({3'h0, p1_oe}, 8'h02, "p1 enable");
        w16(ADR_T2_CNT_LOW, 16'hFFF0);
        wt(1, 1'b0, 300);
        wr(ADR_LVL_P1, 8'h02);
        wr(ADR_T2_CTRL, 8'h05);
        wt(1, 1'b1, 120);
        w16(ADR_T2_CNT_LOW, 16'hFFFE);
        repeat (40) @(posedge clk);
        #1;
        chk({7'h00, p1[1]}, 8'h01, "held past overflow");
        wr(ADR_LVL_P1, 8'h00);
        wt(1, 1'b0, 120);
    endtask

    task automatic s_conc();
        w16(CMP_BASE[4], 16'h0003);
        wr(ADR_LVL_P5, 8'hFF);
        wr(ADR_LVL_P1, 8'h10);
        wr(ADR_CONC_CTRL, 8'h2C);
        w16(ADR_T2_CNT_LOW, 16'h0000);
        wt(4, 1'b1, 120);
        chk({3'h0, irq & 5'h10}, 8'h10, "conc irq");
        chk(p5_oe, 8'h07, "p5 enable");
        chk(p5 & 8'h07, 8'h07, "p5 lines");
    endtask

    task automatic s_ct();
        w16(CMP_BASE[5], 16'hFFF8);
        wr(ADR_P4_TMR_SEL, 8'h01);
        wr(ADR_P4_CMP_EN, 8'h01);
        // compare timer prescaler is fixed, so nothing is left to set before the start
        wr(ADR_CT_RLD_HIGH, 8'hFF);
        wr(ADR_CT_RLD_LOW, 8'hF0);
        wt(5, 1'b1, 120);
        chk(p4_oe, 8'h01, "p4 enable");
        wt(5, 1'b0, 60);
    endtask

    task automatic s_cap();
        wr(ADR_CC_MODE_EN, 8'h13);
        w16(ADR_T2_CNT_LOW, 16'h0200);
        wr(CMP_BASE[0], 8'h55);
        rd(CMP_BASE[0] + 8'h01);
        chk(rv, 8'h02, "capture on write");
        i_pins.cap_edge(2);
        rd(CMP_BASE[2] + 8'h01);
        chk(rv, 8'h02, "capture on pin");
    endtask

    task automatic s_rld();
        wr(ADR_CC_MODE_EN, 8'h00);
        w16(CMP_BASE[0], 16'h1234);
        wr(ADR_T2_CTRL, 8'h19);
        w16(ADR_T2_CNT_LOW, 16'h0000);
        i_pins.reload_fall();
        rd(ADR_T2_CNT_HIGH);
        chk(rv, 8'h12, "pin reload");
        wr(ADR_T2_CTRL, 8'h11);
        w16(ADR_T2_CNT_LOW, 16'hFFFF);
        repeat (20) @(posedge clk);
        rd(ADR_T2_CNT_HIGH);
        chk(rv, 8'h12, "auto reload");
    endtask

    // ==========================================
    // main sequence
    initial begin
        failures = 0;
        n_compared = 0;
        bus = '0;
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        s_regs();
        s_b2b();
        s_cmp();
        s_conc();
        s_ct();
        s_cap();
        s_rld();
        results();
    end
endmodule
`default_nettype wire
